// File: shared/sptsc_pkg.sv
package sptsc_pkg;

  localparam int ADDR_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIV  = 8'h04;
  localparam logic [7:0] OFF_TX0  = 8'h10;
  localparam logic [7:0] OFF_TX1  = 8'h14;
  localparam logic [7:0] OFF_RX0  = 8'h20;
  localparam logic [7:0] OFF_RX1  = 8'h24;

  // Control register fields
  localparam int BIT_GO    = 0;
  localparam int BIT_RXFAL = 1;
  localparam int BIT_TXFAL = 2;
  localparam int LEN_LSB   = 3;
  localparam int LEN_MSB   = 7;
  localparam int CNT_LSB   = 8;
  localparam int CNT_MSB   = 9;
  localparam int BIT_LSBF  = 10;
  localparam int BIT_IDLE  = 11;
  localparam int BIT_DONE  = 16;
  localparam int BIT_SLAVE = 18;
  localparam int BIT_FIFO  = 19;
  localparam int STRB_DONE = 2;
  localparam int STRB_GO   = 0;

  localparam logic [31:0] CFG_MASK   = 32'h000c_0ffe;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [15:0] DIV_RESET  = 16'h0000;

  localparam logic [1:0] COUNT_ONE   = 2'b00;
  localparam logic [1:0] COUNT_BURST = 2'b01;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [5:0] FULL_LEN = 6'h20;

  // Pause between the two words of a burst
  localparam int CLK_PERIOD_NS = 20;
  localparam int GAP_NS        = 80;
  localparam int GAP_CYCLES    = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} sptsc_state_t;

  function automatic logic [5:0] word_len(input logic [4:0] code);
    return (code == 5'h00) ? FULL_LEN : {1'b0, code};
  endfunction

  // Bit position of the n-th bit on the wire
  function automatic logic [4:0] bit_pos(input logic       lsb_first,
                                         input logic [4:0] code,
                                         input logic [5:0] n);
    logic [5:0] p;
    p = lsb_first ? n : 6'(word_len(code) - n - 6'h01);
    return p[4:0];
  endfunction

endpackage

// File: logic/sptsc_sync.sv
`timescale 1ns/1ps
module sptsc_sync #(
  parameter int W = 1
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // sptsc_sync

// File: logic/sptsc_slave_shift.sv
`timescale 1ns/1ps
module sptsc_slave_shift (
  input  wire logic        link_clk,
  input  wire logic        aresetn,
  input  wire logic        select_n,
  input  wire logic        data_in,
  input  wire logic        rx_fall,
  input  wire logic        tx_fall,
  input  wire logic        idle_level,
  input  wire logic        lsb_first,
  input  wire logic [4:0]  len_code,
  input  wire logic        burst,
  input  wire logic [31:0] tx0,
  input  wire logic [31:0] tx1,
  output logic             data_out,
  output logic [31:0]      rx0,
  output logic [31:0]      rx1,
  output logic             done_toggle
);

  // Config is static while armed, so edge choice by xor is glitch free
  logic        sample_clk;
  logic        drive_clk;
  logic [5:0]  in_cnt;
  logic [5:0]  out_cnt;
  logic        in_word;
  logic        out_word;
  logic        drive_seen;
  logic [31:0] acc;
  logic [31:0] acc_next;
  logic [31:0] out_src;
  logic        word_done;

  assign sample_clk = link_clk ^ rx_fall;
  assign drive_clk  = link_clk ^ tx_fall;
  assign word_done  = 6'(in_cnt + 6'h01) == sptsc_pkg::word_len(len_code);
  assign out_src    = out_word ? tx1 : tx0;
  assign data_out   = out_src[sptsc_pkg::bit_pos(lsb_first, len_code, out_cnt)];

  always_comb
  begin
    acc_next = acc;
    acc_next[sptsc_pkg::bit_pos(lsb_first, len_code, in_cnt)] = data_in;
  end

  // Select released restarts the word; a burst needs it held throughout
  always_ff @(posedge sample_clk or posedge select_n)
  begin
    if (select_n)
    begin
      in_cnt  <= 6'h00;
      in_word <= 1'b0;
      acc     <= sptsc_pkg::WORD_RESET;
    end
    else if (word_done)
    begin
      in_cnt  <= 6'h00;
      in_word <= ~in_word;
      acc     <= sptsc_pkg::WORD_RESET;
    end
    else
    begin
      in_cnt <= 6'(in_cnt + 6'h01);
      acc    <= acc_next;
    end
  end

  always_ff @(posedge sample_clk or negedge aresetn)
  begin
    if (!aresetn)
    begin
      rx0         <= sptsc_pkg::WORD_RESET;
      rx1         <= sptsc_pkg::WORD_RESET;
      done_toggle <= 1'b0;
    end
    else if (!select_n && word_done)
    begin
      if (in_word)
        rx1 <= acc_next;
      else
        rx0 <= acc_next;
      if (!burst || in_word)
        done_toggle <= ~done_toggle;
    end
  end

  // First bit is already on the line when driving on the leading edge
  always_ff @(posedge drive_clk or posedge select_n)
  begin
    if (select_n)
    begin
      out_cnt    <= 6'h00;
      out_word   <= 1'b0;
      drive_seen <= 1'b0;
    end
    else
    begin
      drive_seen <= 1'b1;
      if (drive_seen || tx_fall != idle_level)
      begin
        if (6'(out_cnt + 6'h01) == sptsc_pkg::word_len(len_code))
        begin
          out_cnt  <= 6'h00;
          out_word <= ~out_word;
        end
        else
          out_cnt <= 6'(out_cnt + 6'h01);
      end
    end
  end

endmodule // sptsc_slave_shift

// File: logic/sptsc_ctrl.sv
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - LSB first: low bit out, first in at 0
// - Otherwise MSB first, position from length
// - Word count 00 single, 01 burst
// - Length 1 to 31, code 0 is 32
// - Output edge bit: 1 falling, 0 rising
// - Input edge bit: 1 falling, 0 rising
// - Master: writing go starts a transfer
// - Slave: writing go arms the device
// - Writing 0 during transfer stops it, except in FIFO mode
// - Go reads 1 while busy, self clears
// - FIFO mode: hardware owns go bit
// - Clock idle level 1 rests high
// - Done flag cleared only by writing 1
module sptsc_ctrl #(
  parameter int GAP_LEN = sptsc_pkg::GAP_CYCLES
)(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [sptsc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [sptsc_pkg::ADDR_W-1:0] araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  input  wire logic                         serial_clock_in,
  input  wire logic                         select_in_n,
  input  wire logic                         serial_data_in,
  output logic                              serial_clock_pin,
  output logic                              select_out_n,
  output logic                              serial_data_out,
  output logic                              serial_data_out_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [sptsc_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0]                  w_data_q;
  logic [3:0]                   w_strb_q;
  logic                         aw_got;
  logic                         w_got;
  logic                         wr_fire;
  logic [31:0]                  cfg_q;
  logic [15:0]                  div_q;
  logic [31:0]                  tx0_q;
  logic [31:0]                  tx1_q;
  logic [31:0]                  rx0_q;
  logic [31:0]                  rx1_q;
  logic                         go;
  logic                         done_flag;
  logic                         wr_ctrl;
  logic                         sw_go1;
  logic                         sw_go0;
  logic                         start;
  logic                         stop;
  logic                         hw_finish;
  sptsc_pkg::sptsc_state_t      state;
  logic [15:0]                  div_cnt;
  logic [5:0]                   edge_idx;
  logic                         word_sel;
  logic [7:0]                   gap_cnt;
  logic [31:0]                  rx_acc;
  logic [31:0]                  rx_next;
  logic                         dout_q;
  logic                         tick;
  logic                         is_tx;
  logic                         is_rx;
  logic                         word_end;
  logic                         master_finish;
  logic [6:0]                   edge_plus;
  logic [5:0]                   next_bit;
  logic [31:0]                  cur_word;
  logic                         rx_fall;
  logic                         tx_fall;
  logic                         lsb_first;
  logic                         idle_level;
  logic                         slave_role;
  logic                         fifo_mode;
  logic                         burst;
  logic [4:0]                   len_code;
  logic [5:0]                   len;
  logic                         din_s;
  logic                         sel_s;
  logic                         tog_s;
  logic                         tog_d;
  logic                         slave_finish;
  logic                         slave_dout;
  logic [31:0]                  slave_rx0;
  logic [31:0]                  slave_rx1;
  logic                         slave_tog;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic mapped(input logic [sptsc_pkg::ADDR_W-1:0] a);
    if (a == sptsc_pkg::OFF_CTRL || a == sptsc_pkg::OFF_DIV)
      return 1'b1;
    else if (a == sptsc_pkg::OFF_TX0 || a == sptsc_pkg::OFF_TX1)
      return 1'b1;
    else if (a == sptsc_pkg::OFF_RX0 || a == sptsc_pkg::OFF_RX1)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  assign rx_fall    = cfg_q[sptsc_pkg::BIT_RXFAL];
  assign tx_fall    = cfg_q[sptsc_pkg::BIT_TXFAL];
  assign lsb_first  = cfg_q[sptsc_pkg::BIT_LSBF];
  assign idle_level = cfg_q[sptsc_pkg::BIT_IDLE];
  assign slave_role = cfg_q[sptsc_pkg::BIT_SLAVE];
  assign fifo_mode  = cfg_q[sptsc_pkg::BIT_FIFO];
  assign len_code   = cfg_q[sptsc_pkg::LEN_MSB:sptsc_pkg::LEN_LSB];
  assign len        = sptsc_pkg::word_len(len_code);
  // Reserved count codes behave as a single word
  assign burst = cfg_q[sptsc_pkg::CNT_MSB:sptsc_pkg::CNT_LSB] == sptsc_pkg::COUNT_BURST;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign wr_fire = aw_got && w_got && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= sptsc_pkg::RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= sptsc_pkg::WORD_RESET;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (!aw_got && !awready && !bvalid)
        awready <= 1'b1;
      if (!w_got && !wready && !bvalid)
        wready <= 1'b1;
      if (awvalid && awready)
      begin
        aw_got    <= 1'b1;
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got    <= 1'b1;
        wready   <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= mapped(aw_addr_q) ? sptsc_pkg::RESP_OKAY : sptsc_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= sptsc_pkg::WORD_RESET;
      rresp   <= sptsc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= sptsc_pkg::RESP_OKAY;
      if (araddr == sptsc_pkg::OFF_CTRL)
      begin
        rdata <= cfg_q;
        rdata[sptsc_pkg::BIT_GO]   <= go;
        rdata[sptsc_pkg::BIT_DONE] <= done_flag;
      end
      else if (araddr == sptsc_pkg::OFF_DIV)
        rdata <= {16'h0000, div_q};
      else if (araddr == sptsc_pkg::OFF_TX0)
        rdata <= tx0_q;
      else if (araddr == sptsc_pkg::OFF_TX1)
        rdata <= tx1_q;
      else if (araddr == sptsc_pkg::OFF_RX0)
        rdata <= rx0_q;
      else if (araddr == sptsc_pkg::OFF_RX1)
        rdata <= rx1_q;
      else
      begin
        rdata <= sptsc_pkg::WORD_RESET;
        rresp <= sptsc_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers

  assign wr_ctrl = wr_fire && aw_addr_q == sptsc_pkg::OFF_CTRL;
  assign sw_go1  = wr_ctrl && w_strb_q[sptsc_pkg::STRB_GO] && w_data_q[sptsc_pkg::BIT_GO];
  assign sw_go0  = wr_ctrl && w_strb_q[sptsc_pkg::STRB_GO] && !w_data_q[sptsc_pkg::BIT_GO];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q <= sptsc_pkg::WORD_RESET;
      div_q <= sptsc_pkg::DIV_RESET;
      tx0_q <= sptsc_pkg::WORD_RESET;
      tx1_q <= sptsc_pkg::WORD_RESET;
    end
    else if (wr_fire)
    begin
      if (aw_addr_q == sptsc_pkg::OFF_CTRL)
        cfg_q <= merge(cfg_q, w_data_q, w_strb_q) & sptsc_pkg::CFG_MASK;
      else if (aw_addr_q == sptsc_pkg::OFF_DIV)
        div_q <= 16'(merge({16'h0000, div_q}, w_data_q, w_strb_q));
      else if (aw_addr_q == sptsc_pkg::OFF_TX0)
        tx0_q <= merge(tx0_q, w_data_q, w_strb_q);
      else if (aw_addr_q == sptsc_pkg::OFF_TX1)
        tx1_q <= merge(tx1_q, w_data_q, w_strb_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Go/busy and done

  // FIFO mode: software writes to go are ignored, a TX0 word load starts it
  assign start = !go && (fifo_mode ? (wr_fire && aw_addr_q == sptsc_pkg::OFF_TX0)
                                   : sw_go1);
  assign stop  = go && sw_go0 && !fifo_mode;

  assign slave_finish = (tog_s != tog_d) && go && slave_role;
  assign hw_finish    = master_finish || slave_finish;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      go <= 1'b0;
    else if (hw_finish || stop)
      go <= 1'b0;
    else if (start)
      go <= 1'b1;
  end

  // Completion wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_flag <= 1'b0;
    else if (hw_finish)
      done_flag <= 1'b1;
    else if (wr_ctrl && w_strb_q[sptsc_pkg::STRB_DONE] && w_data_q[sptsc_pkg::BIT_DONE])
      done_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master engine

  assign tick      = state == sptsc_pkg::ST_RUN && div_cnt == div_q;
  assign is_tx     = tick && (tx_fall ? serial_clock_pin : !serial_clock_pin);
  assign is_rx     = tick && (rx_fall ? serial_clock_pin : !serial_clock_pin);
  assign edge_plus = 7'({1'b0, edge_idx} + 7'h01);
  assign next_bit  = edge_plus[6:1];
  assign word_end  = tick && edge_plus == {len, 1'b0};
  assign master_finish = word_end && !(burst && !word_sel);
  assign cur_word  = word_sel ? tx1_q : tx0_q;

  always_comb
  begin
    rx_next = rx_acc;
    if (is_rx)
      rx_next[sptsc_pkg::bit_pos(lsb_first, len_code, edge_idx >> 1)] = din_s;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state            <= sptsc_pkg::ST_IDLE;
      serial_clock_pin <= 1'b0;
      select_out_n     <= 1'b1;
      div_cnt          <= 16'h0000;
      edge_idx         <= 6'h00;
      word_sel         <= 1'b0;
      gap_cnt          <= 8'h00;
      rx_acc           <= sptsc_pkg::WORD_RESET;
      dout_q           <= 1'b0;
    end
    else if (stop)
    begin
      state            <= sptsc_pkg::ST_IDLE;
      serial_clock_pin <= idle_level;
      select_out_n     <= 1'b1;
    end
    else
    begin
      case (state)
        sptsc_pkg::ST_IDLE:
        begin
          serial_clock_pin <= idle_level;
          select_out_n     <= 1'b1;
          if (start && !slave_role)
          begin
            state        <= sptsc_pkg::ST_RUN;
            select_out_n <= 1'b0;
            div_cnt      <= 16'h0000;
            edge_idx     <= 6'h00;
            word_sel     <= 1'b0;
            rx_acc       <= sptsc_pkg::WORD_RESET;
            dout_q       <= 1'(merge(tx0_q, w_data_q, fifo_mode ? w_strb_q : 4'h0) >>
                               sptsc_pkg::bit_pos(lsb_first, len_code, 6'h00));
          end
        end
        sptsc_pkg::ST_RUN:
        begin
          div_cnt <= tick ? 16'h0000 : 16'(div_cnt + 16'h0001);
          if (tick)
          begin
            serial_clock_pin <= ~serial_clock_pin;
            rx_acc           <= rx_next;
            edge_idx         <= 6'(edge_plus);
            if (is_tx && edge_idx != 6'h00 && next_bit < len)
              dout_q <= cur_word[sptsc_pkg::bit_pos(lsb_first, len_code, next_bit)];
          end
          if (master_finish)
            state <= sptsc_pkg::ST_IDLE;
          else if (word_end)
          begin
            state    <= sptsc_pkg::ST_GAP;
            word_sel <= 1'b1;
            gap_cnt  <= 8'h00;
          end
        end
        sptsc_pkg::ST_GAP:
        begin
          gap_cnt <= 8'(gap_cnt + 8'h01);
          if (gap_cnt == 8'(GAP_LEN - 1))
          begin
            state    <= sptsc_pkg::ST_RUN;
            div_cnt  <= 16'h0000;
            edge_idx <= 6'h00;
            rx_acc   <= sptsc_pkg::WORD_RESET;
            dout_q   <= tx1_q[sptsc_pkg::bit_pos(lsb_first, len_code, 6'h00)];
          end
        end
        default:
          state <= sptsc_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive words

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx0_q <= sptsc_pkg::WORD_RESET;
      rx1_q <= sptsc_pkg::WORD_RESET;
    end
    else if (word_end && !word_sel)
      rx0_q <= rx_next;
    else if (word_end)
      rx1_q <= rx_next;
    else if (slave_finish)
    begin
      // Holders in the link domain are stable once the toggle arrives
      rx0_q <= slave_rx0;
      rx1_q <= slave_rx1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave side and crossings

  sptsc_sync #(
    .W (3)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({serial_data_in, select_in_n, slave_tog}),
    .q       ({din_s, sel_s, tog_s})
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tog_d              <= 1'b0;
      serial_data_out_en <= 1'b0;
    end
    else
    begin
      tog_d              <= tog_s;
      serial_data_out_en <= slave_role ? (go && !sel_s) : 1'b1;
    end
  end

  sptsc_slave_shift u_slave (
    .link_clk    (serial_clock_in),
    .aresetn     (aresetn),
    .select_n    (select_in_n),
    .data_in     (serial_data_in),
    .rx_fall     (rx_fall),
    .tx_fall     (tx_fall),
    .idle_level  (idle_level),
    .lsb_first   (lsb_first),
    .len_code    (len_code),
    .burst       (burst),
    .tx0         (tx0_q),
    .tx1         (tx1_q),
    .data_out    (slave_dout),
    .rx0         (slave_rx0),
    .rx1         (slave_rx1),
    .done_toggle (slave_tog)
  );

  // Slave bit must follow the link clock, so it bypasses the aclk flop
  assign serial_data_out = slave_role ? slave_dout : dout_q;

endmodule // sptsc_ctrl

// File: verif/sptsc_assertions.sv
`timescale 1ns/1ps
module sptsc_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic serial_clock_pin,
  input wire logic select_out_n,
  input wire logic serial_data_out_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence rd_taken; arvalid && arready; endsequence
  AST_B_TIME: assert property (wr_taken |-> ##2 bvalid) else $error("late b");
  AST_B_STAND: assert property (bvalid && !bready |=> bvalid) else $error("b dropped");
  AST_AW_HOLD: assert property (wr_taken |=> !awready [*2]) else $error("aw reopened");
  AST_R_TIME: assert property (rd_taken |=> rvalid) else $error("late r");
  AST_R_STAND: assert property (rvalid && !rready |=> rvalid) else $error("r dropped");
  AST_AR_HOLD: assert property (rd_taken |=> !arready) else $error("ar reopened");
  AST_OE_RUN: assert property (!select_out_n |-> serial_data_out_en) else $error("oe");
  AST_CLK_REST: assert property ($fell(select_out_n) |-> $stable(serial_clock_pin))
    else $error("clock moved at start");
endmodule // sptsc_assertions
////////////////////////////////////////////////////////////////////////////////
bind sptsc_ctrl sptsc_assertions chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .serial_clock_pin, .select_out_n,
  .serial_data_out_en);

// File: verif/sptsc_partner.sv
`timescale 1ns/1ps
module sptsc_partner (
  input  wire logic serial_clock_pin,
  input  wire logic select_out_n,
  input  wire logic serial_data_out,
  output logic      serial_clock_in = 1'h0,
  output logic      select_in_n = 1'h1,
  output logic      serial_data_in = 1'h0
);
  logic [31:0] sh = 32'h0;
  logic [31:0] cap = 32'h0;
  // Slave of a master run: launch on fall, sample on rise
  always @(negedge select_out_n) serial_data_in = sh[31];
  always @(posedge serial_clock_pin) if (!select_out_n) cap = {cap[30:0], serial_data_out};
  always @(negedge serial_clock_pin) if (!select_out_n) {serial_data_in, sh} = {sh[30], sh << 1};
  // Released line flips, so a stale level never passes
  always @(posedge select_out_n) serial_data_in = ~serial_data_in;
  task automatic drive_frame(input int n);
    select_in_n = 1'h0;
    serial_data_in = sh[31];
    repeat (n)
    begin
      #7.5 serial_clock_in = 1'h1;
      cap = {cap[30:0], serial_data_out};
      #7.5 serial_clock_in = 1'h0;
      sh = sh << 1;
      serial_data_in = sh[31];
    end
    #7.5 select_in_n = 1'h1;
    serial_data_in = ~serial_data_in;
  endtask
endmodule // sptsc_partner

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
  logic        arvalid = 1'h0, rready = 1'h1, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, rsp;
  logic        serial_clock_in, select_in_n, serial_data_in;
  logic        serial_clock_pin, select_out_n, serial_data_out, serial_data_out_en;
  int          err_total = 0, check_count = 0;
  always #10 aclk = ~aclk;
  sptsc_ctrl DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .serial_clock_in, .select_in_n, .serial_data_in, .serial_clock_pin,
    .select_out_n, .serial_data_out, .serial_data_out_en);
  sptsc_partner peer (.serial_clock_pin, .select_out_n, .serial_data_out, .serial_clock_in,
    .select_in_n, .serial_data_in);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (!bvalid);
    rsp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end
    while (!rvalid);
    rv = rdata;
    rsp = rresp;
  endtask
  function automatic logic [31:0] rev(input logic [31:0] x);
    for (int i = 0; i < 32; i++) rev[i] = x[31-i];
  endfunction
  // Polling keeps the bus busy; the watchdog bounds it
  task automatic wait_idle();
    do rd(sptsc_pkg::OFF_CTRL);
    while (rv[0] !== 1'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(sptsc_pkg::OFF_CTRL);
    chk(sptsc_pkg::WORD_RESET, rv, "ctrl reset");
    wr(8'h08, 32'h1);
    chk(32'h2, {30'h0, rsp}, "unmapped write resp");
    rd(8'h08);
    chk(32'h2, {30'h0, rsp}, "unmapped read resp");
    chk(32'h0, rv, "unmapped read data");
    wr(sptsc_pkg::OFF_CTRL, 32'h800);
    repeat (2) @(posedge aclk);
    chk(32'h1, {31'h0, serial_clock_pin}, "clock rest high");
    wr(sptsc_pkg::OFF_CTRL, 32'h0);
    wr(sptsc_pkg::OFF_DIV, 32'h3);
    rd(sptsc_pkg::OFF_DIV);
    chk(32'h3, rv, "divider");
    $display("end regs");
  endtask
  task automatic t_master(input logic lsb, input logic [4:0] code, input logic cnt);
    logic [31:0] t0, t1, pat, m, c, eo, er;
    int n;
    n = (code == 5'h0) ? 32 : int'(code);
    m = (n == 32) ? 32'hffff_ffff : (32'h1 << n) - 32'h1;
    t0 = 32'hc3a5_5a3c ^ {27'h0, code};
    t1 = 32'h9e37_79b9;
    pat = 32'hb4e1_0f6d;
    peer.sh = pat;
    wr(sptsc_pkg::OFF_TX0, t0);
    wr(sptsc_pkg::OFF_TX1, t1);
    c = {20'h0, 1'h0, lsb, 1'h0, cnt, code, 3'h4};
    wr(sptsc_pkg::OFF_CTRL, c);
    wr(sptsc_pkg::OFF_CTRL, c | 32'h1);
    rd(sptsc_pkg::OFF_CTRL);
    chk(32'h1, {31'h0, rv[0]}, "busy");
    wait_idle();
    chk(32'h1, {31'h0, rv[16]}, "done");
    eo = lsb ? rev(t0) >> (32 - n) : t0;
    er = lsb ? rev(pat) : pat >> (32 - n);
    rd(sptsc_pkg::OFF_RX0);
    chk(er & m, rv & m, "word in");
    if (cnt)
    begin
      rd(sptsc_pkg::OFF_RX1);
      chk(pat & m, rv & m, "second word in");
      eo = {eo[15:0], t1[15:0]};
      m = 32'hffff_ffff;
    end
    chk(eo & m, peer.cap & m, "word out");
    wr(sptsc_pkg::OFF_CTRL, 32'h1_0000);
    $display("end master %0d", n);
  endtask
  task automatic t_stop();
    wr(sptsc_pkg::OFF_CTRL, 32'h5);
    wr(sptsc_pkg::OFF_CTRL, 32'h4);
    rd(sptsc_pkg::OFF_CTRL);
    chk(32'h4, rv, "stopped, no done");
    repeat (8) @(posedge aclk);
    chk(32'h1, {31'h0, select_out_n}, "select released");
    wr(sptsc_pkg::OFF_CTRL, 32'h8_0004);
    wr(sptsc_pkg::OFF_TX0, 32'h0);
    wr(sptsc_pkg::OFF_CTRL, 32'h8_0004);
    rd(sptsc_pkg::OFF_CTRL);
    chk(32'h8_0005, rv, "fifo owns go");
    wait_idle();
    wr(sptsc_pkg::OFF_CTRL, 32'h1_0000);
    $display("end stop");
  endtask
  task automatic t_slave();
    peer.sh = 32'h9600_0000;
    wr(sptsc_pkg::OFF_TX0, 32'hc5);
    wr(sptsc_pkg::OFF_CTRL, 32'h4_0044);
    wr(sptsc_pkg::OFF_CTRL, 32'h4_0045);
    #3 peer.drive_frame(8);
    @(posedge aclk);
    wait_idle();
    chk(32'hc5, peer.cap & 32'hff, "slave out");
    chk(32'h0, {31'h0, serial_data_out_en}, "slave line released");
    rd(sptsc_pkg::OFF_RX0);
    chk(32'h96, rv & 32'hff, "slave in");
    $display("end slave");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_master(1'h0, 5'h08, 1'h0);
    t_master(1'h1, 5'h00, 1'h0);
    t_master(1'h0, 5'h01, 1'h0);
    t_master(1'h0, 5'h10, 1'h1);
    t_stop();
    t_slave();
    close_out();
  end
  initial
  begin
    #400000;
    err_total++;
    close_out();
  end
endmodule // tb
